// >>> bench/ata_host_model.sv
`timescale 1ns/1ps
module ata_host_model (
  // Clock
  input wire logic sys_clk_i,
  // Task-file drive toward the device
  output logic [9:0] tf_addr_o,
  output logic tf_wr_o,
  output logic tf_rd_o,
  output logic [7:0] tf_wdata_o,
  // Device answers
  input wire logic [7:0] tf_rdata_i,
  input wire logic intrq_i
);
  import ata_feat_pkg::*;

  // ****************************
  // Host side bus cycles
  // ****************************
  // Idle bus at time zero
  initial begin
    tf_addr_o = 10'h000;
    tf_wr_o = 1'b0;
    tf_rd_o = 1'b0;
    tf_wdata_o = 8'h00;
  end

  // One write strobe, driven on falling edges only
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    tf_addr_o = a;
    tf_wdata_o = d;
    tf_wr_o = 1'b1;
    @(negedge sys_clk_i);
    tf_wr_o = 1'b0;
    tf_wdata_o = ~d; // Released data must not look valid
  endtask

  // Read strobe, data registered one cycle later
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(negedge sys_clk_i);
    tf_addr_o = a;
    tf_rd_o = 1'b1;
    @(negedge sys_clk_i);
    tf_rd_o = 1'b0;
    d = tf_rdata_i;
  endtask

  // Parameters first, then the opcode; no polling shortcut
  task automatic issue(input logic [7:0] feat, input logic [7:0] cnt, input logic [7:0] cmd);
    wr(FEAT_FAULT_OFS, feat);
    wr(BLOCK_COUNT_OFS, cnt);
    wr(CMD_FLAGS_OFS, cmd);
  endtask

  // Bounded wait for completion interrupt
  task automatic wait_irq(output logic seen);
    seen = 1'b0;
    for (int i = 0; i < 16 && !seen; i++) begin
      @(negedge sys_clk_i);
      seen = (intrq_i === 1'b1);
    end
  endtask
endmodule

// >>> bench/ata_set_features_handler_tb.sv
`timescale 1ns/1ps
module ata_set_features_handler_tb;
  import ata_feat_pkg::*;

  // ****************************
  // Signals and instances
  // ****************************
  logic sys_clk_i;
  logic nrst_i;
  logic soft_reset_i;
  logic [9:0] tf_addr;
  logic tf_wr;
  logic tf_rd;
  logic [7:0] tf_wdata;
  logic [7:0] tf_rdata;
  logic intrq;
  opts_t opts;
  logic pio4_ok;
  logic mdma2_ok;
  int failures;
  int n_compared;
  int cycles;
  opts_t exp;
  logic [7:0] v;
  logic seen;
  logic [7:0] good_cnt [17] = '{8'h00, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h20, 8'h21, 8'h22,
                                8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h00, 8'h0c, 8'h22};
  logic [7:0] bad_cnt [6] = '{8'h01, 8'h0d, 8'h23, 8'h45, 8'h10, 8'h80};

  ata_set_features_handler u_dut (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .tf_addr_i(tf_addr), .tf_wr_i(tf_wr), .tf_rd_i(tf_rd),
    .tf_wdata_i(tf_wdata), .tf_rdata_o(tf_rdata), .intrq_o(intrq), .soft_reset_i(soft_reset_i),
    .opts_o(opts), .pio4_ok_o(pio4_ok), .mdma2_ok_o(mdma2_ok));

  ata_host_model u_host (
    .sys_clk_i(sys_clk_i), .tf_addr_o(tf_addr), .tf_wr_o(tf_wr), .tf_rd_o(tf_rd),
    .tf_wdata_o(tf_wdata), .tf_rdata_i(tf_rdata), .intrq_i(intrq));

  // 200 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  // Hang guard, far above the several hundred cycles needed
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      end_sim();
    end
  end

  // ****************************
  // Checks and sequences
  // ****************************
  task automatic end_sim();
    if (failures == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [12:0] e, input logic [12:0] s);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, e, s);
    end
  endtask

  // Full command, then completion, flags, fault and option state
  task automatic run(input logic [7:0] feat, input logic [7:0] cnt, input logic [7:0] cmd, input logic ab);
    u_host.issue(feat, cnt, cmd);
    u_host.wait_irq(seen);
    chk("intrq", 13'h1, {12'h0, seen});
    u_host.rd(CMD_FLAGS_OFS, v);
    chk("flags", ab ? 13'h51 : 13'h50, {5'h0, v});
    chk("intrq_clr", 13'h0, {12'h0, intrq});
    u_host.rd(FEAT_FAULT_OFS, v);
    chk("fault", ab ? 13'h04 : 13'h00, {5'h0, v});
    chk("opts", exp, opts);
  endtask

  task automatic pulse_soft_reset();
    @(negedge sys_clk_i);
    soft_reset_i = 1'b1;
    @(negedge sys_clk_i);
    soft_reset_i = 1'b0;
    @(negedge sys_clk_i);
  endtask

  initial begin
    nrst_i = 1'b0;
    soft_reset_i = 1'b0;
    failures = 0;
    n_compared = 0;
    cycles = 0;
    exp = OPTS_DEFAULT;
    repeat (8) @(negedge sys_clk_i);
    nrst_i = 1'b1;
    chk("opts_rst", OPTS_DEFAULT, opts);
    chk("ok_rst", 13'h3, {11'h0, pio4_ok, mdma2_ok});
    u_host.rd(10'h1f0, v);
    chk("unmapped", 13'h0, {5'h0, v});
    // Busy window: flags show BSY, writes are refused
    u_host.wr(SECTOR_NUM_OFS, 8'h5a);
    u_host.wr(FEAT_FAULT_OFS, 8'h04);
    u_host.wr(CMD_FLAGS_OFS, CMD_SET_FEATURES);
    u_host.wr(SECTOR_NUM_OFS, 8'ha5);
    // Flags read on the last busy edge; completion must still keep the interrupt
    u_host.rd(CMD_FLAGS_OFS, v);
    chk("bsy", 13'h2, {11'h0, v[7:6]});
    u_host.wait_irq(seen);
    chk("intrq_busy", 13'h1, {12'h0, seen});
    u_host.rd(SECTOR_NUM_OFS, v);
    chk("refused_wr", 13'h5a, {5'h0, v});
    // Option codes, each inverts state away from default first
    exp.wcache = 1'b0;
    run(FC_WCACHE_OFF, 8'h00, CMD_SET_FEATURES, 1'b0);
    exp.wcache = 1'b1;
    run(FC_WCACHE_ON, 8'h00, CMD_SET_FEATURES, 1'b0);
    exp.rcache = 1'b0;
    run(FC_RCACHE_OFF, 8'h00, CMD_SET_FEATURES, 1'b0);
    exp.rcache = 1'b1;
    run(FC_RCACHE_ON, 8'h00, CMD_SET_FEATURES, 1'b0);
    exp.apm = 1'b0;
    run(FC_APM_OFF, 8'h00, CMD_SET_FEATURES, 1'b0);
    exp.apm = 1'b1;
    run(FC_APM_ON, 8'h00, CMD_SET_FEATURES, 1'b0);
    exp.ecc4 = 1'b1;
    run(FC_ECC4_LONG, 8'h00, CMD_SET_FEATURES, 1'b0);
    exp.wcache = 1'b0;
    run(FC_WCACHE_OFF, 8'h00, CMD_SET_FEATURES, 1'b0);
    for (int i = 0; i < NOP_CODES; i++) run(NOP_LIST[i], 8'h0c, CMD_SET_FEATURES, 1'b0);
    run(8'h01, 8'h00, CMD_SET_FEATURES, 1'b1);
    run(8'hff, 8'h00, CMD_SET_FEATURES, 1'b1);
    run(FC_WCACHE_ON, 8'h00, 8'h20, 1'b1);
    // Transfer selections: type is the upper five bits, mode the lower three
    for (int i = 0; i < 17; i++) begin
      exp.xtype = good_cnt[i][7:3];
      exp.xmode = good_cnt[i][2:0];
      run(FC_XFER_MODE, good_cnt[i], CMD_SET_FEATURES, 1'b0);
    end
    chk("ok_sel", 13'h3, {11'h0, pio4_ok, mdma2_ok});
    for (int i = 0; i < 6; i++) run(FC_XFER_MODE, bad_cnt[i], CMD_SET_FEATURES, 1'b1);
    // Soft reset keeps options, then reverts once re-armed
    exp.keep = 1'b1;
    run(FC_KEEP_ON_SRST, 8'h00, CMD_SET_FEATURES, 1'b0);
    pulse_soft_reset();
    chk("opts_keep", exp, opts);
    exp.keep = 1'b0;
    run(FC_REVERT_ON_SRST, 8'h00, CMD_SET_FEATURES, 1'b0);
    pulse_soft_reset();
    chk("opts_revert", OPTS_DEFAULT, opts);
    end_sim();
  end
endmodule

// >>> design/ata_feat_pkg.sv
package ata_feat_pkg;

  // ************************************
  // Task-file port addresses
  // ************************************
  localparam logic [9:0] FEAT_FAULT_OFS = 10'h1f1;
  localparam logic [9:0] BLOCK_COUNT_OFS = 10'h1f2;
  localparam logic [9:0] SECTOR_NUM_OFS = 10'h1f3;
  localparam logic [9:0] CYL_LOWER_OFS = 10'h1f4;
  localparam logic [9:0] CYL_UPPER_OFS = 10'h1f5;
  localparam logic [9:0] UNIT_HEAD_OFS = 10'h1f6;
  localparam logic [9:0] CMD_FLAGS_OFS = 10'h1f7;
  localparam logic [7:0] TF_RESET_VAL = 8'h00;

  // ************************************
  // Condition flag and fault bit positions
  // ************************************
  localparam int FLAG_BSY_BIT = 7;
  localparam int FLAG_DRDY_BIT = 6;
  localparam int FLAG_DSC_BIT = 4;
  localparam int FLAG_ERR_BIT = 0;
  localparam int FAULT_ABRT_BIT = 2;

  // ************************************
  // Command and feature codes
  // ************************************
  localparam logic [7:0] CMD_SET_FEATURES = 8'hef;
  localparam logic [7:0] FC_WCACHE_ON = 8'h02;
  localparam logic [7:0] FC_XFER_MODE = 8'h03;
  localparam logic [7:0] FC_APM_ON = 8'h05;
  localparam logic [7:0] FC_RCACHE_OFF = 8'h55;
  localparam logic [7:0] FC_KEEP_ON_SRST = 8'h66;
  localparam logic [7:0] FC_WCACHE_OFF = 8'h82;
  localparam logic [7:0] FC_APM_OFF = 8'h85;
  localparam logic [7:0] FC_RCACHE_ON = 8'haa;
  localparam logic [7:0] FC_ECC4_LONG = 8'hbb;
  localparam logic [7:0] FC_REVERT_ON_SRST = 8'hcc;
  localparam int NOP_CODES = 9;
  localparam logic [7:0] NOP_LIST [NOP_CODES] = '{8'h04, 8'h33, 8'h54, 8'h77, 8'h81,
                                                  8'h84, 8'h88, 8'h89, 8'hab};

  // ************************************
  // Transfer-mode selection fields
  // ************************************
  localparam int XFER_MODE_W = 3;
  localparam int XFER_TYPE_W = 5;
  localparam logic [4:0] XT_PIO_DEFAULT = 5'h00;
  localparam logic [4:0] XT_PIO_FLOW = 5'h01;
  localparam logic [4:0] XT_MW_DMA = 5'h04;
  localparam logic [4:0] XT_ULTRA_DMA = 5'h08;
  localparam logic [2:0] PIO_MODE_MAX = 3'h4;
  localparam logic [2:0] MDMA_MODE_MAX = 3'h2;
  localparam logic [2:0] UDMA_MODE_MAX = 3'h4;

  // ************************************
  // Timing
  // ************************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam int BUSY_TIME_NS = 20;
  localparam int BUSY_CYCLES = (BUSY_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int BUSY_CNT_W = 3;

  // ************************************
  // Types
  // ************************************
  typedef enum logic [3:0] {
    ACT_ABORT, ACT_NOP, ACT_WC_ON, ACT_WC_OFF, ACT_RC_ON, ACT_RC_OFF,
    ACT_APM_ON, ACT_APM_OFF, ACT_KEEP, ACT_REVERT, ACT_ECC4, ACT_XFER
  } feat_act_t;

  typedef struct packed {
    logic ok;
    logic [4:0] xtype;
    logic [2:0] xmode;
  } xfer_sel_t;

  typedef struct packed {
    logic wcache;
    logic rcache;
    logic apm;
    logic keep;
    logic ecc4;
    logic [4:0] xtype;
    logic [2:0] xmode;
  } opts_t;

  localparam opts_t OPTS_DEFAULT = '{wcache: 1'b1, rcache: 1'b1, apm: 1'b1, keep: 1'b0,
                                     ecc4: 1'b0, xtype: 5'h00, xmode: 3'h0};

endpackage

// >>> design/ata_set_features_handler.sv
`timescale 1ns/1ps
module ata_set_features_handler (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Task-file access from the host
  input wire logic [9:0] tf_addr_i,
  input wire logic tf_wr_i,
  input wire logic tf_rd_i,
  input wire logic [7:0] tf_wdata_i,
  output logic [7:0] tf_rdata_o,
  output logic intrq_o,
  // Soft reset request
  input wire logic soft_reset_i,
  // Drive option state
  output ata_feat_pkg::opts_t opts_o,
  output logic pio4_ok_o,
  output logic mdma2_ok_o
);
  import ata_feat_pkg::*;

  // ************************************
  // Declarations
  // ************************************
  typedef enum logic [1:0] {S_IDLE, S_BUSY} state_t;

  state_t state_q, state_d;
  logic [7:0] feat_q, count_q, secnum_q;
  logic [7:0] cyl_lo_q, cyl_hi_q, unit_q;
  logic [7:0] feat_cap_q, count_cap_q;
  logic [7:0] fault_q, fault_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] flags_w;
  logic [BUSY_CNT_W-1:0] cnt_q;
  logic setf_q, err_q, err_d;
  logic intrq_q, intrq_d, bsy_q;
  logic caps_q;
  opts_t opts_q, opts_d;
  xfer_sel_t xsel;
  feat_act_t act;
  logic idle_w, wr_ok_w, exec_w, abort_w;
  logic wr_feat_w, wr_count_w, wr_secnum_w;
  logic wr_cyl_lo_w, wr_cyl_hi_w, wr_unit_w, wr_cmd_w;
  logic rd_flags_w, irq_clr_w;

  // ************************************
  // Decoders
  // ************************************
  xfer_mode_decode u_xfer (
    .count_i(count_cap_q),
    .sel_o(xsel)
  );

  feature_decode u_feat (
    .feat_i(feat_cap_q),
    .xfer_ok_i(xsel.ok),
    .act_o(act)
  );

  // ************************************
  // Address decode
  // ************************************
  // Host writes are ignored while BSY stands
  assign idle_w = state_q == S_IDLE;
  assign wr_ok_w = tf_wr_i && idle_w;
  assign wr_feat_w = wr_ok_w && tf_addr_i == FEAT_FAULT_OFS;
  assign wr_count_w = wr_ok_w && tf_addr_i == BLOCK_COUNT_OFS;
  assign wr_secnum_w = wr_ok_w && tf_addr_i == SECTOR_NUM_OFS;
  assign wr_cyl_lo_w = wr_ok_w && tf_addr_i == CYL_LOWER_OFS;
  assign wr_cyl_hi_w = wr_ok_w && tf_addr_i == CYL_UPPER_OFS;
  assign wr_unit_w = wr_ok_w && tf_addr_i == UNIT_HEAD_OFS;
  assign wr_cmd_w = wr_ok_w && tf_addr_i == CMD_FLAGS_OFS;
  assign rd_flags_w = tf_rd_i && tf_addr_i == CMD_FLAGS_OFS;

  // Execution point is the last busy cycle
  assign exec_w = state_q == S_BUSY && cnt_q == '0;
  assign abort_w = exec_w && (!setf_q || act == ACT_ABORT);

  // ************************************
  // Parameter ports
  // ************************************
  // Host must load these before the command
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      feat_q <= TF_RESET_VAL;
      count_q <= TF_RESET_VAL;
      secnum_q <= TF_RESET_VAL;
    end else begin
      if (wr_feat_w) feat_q <= tf_wdata_i;
      if (wr_count_w) count_q <= tf_wdata_i;
      if (wr_secnum_w) secnum_q <= tf_wdata_i;
    end
  end

  // Address ports, stored but not used here
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      cyl_lo_q <= TF_RESET_VAL;
      cyl_hi_q <= TF_RESET_VAL;
      unit_q <= TF_RESET_VAL;
    end else begin
      if (wr_cyl_lo_w) cyl_lo_q <= tf_wdata_i;
      if (wr_cyl_hi_w) cyl_hi_q <= tf_wdata_i;
      if (wr_unit_w) unit_q <= tf_wdata_i;
    end
  end

  // ************************************
  // Command sequencing
  // ************************************
  // Idle until a command byte, then a fixed busy span
  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: if (wr_cmd_w) state_d = S_BUSY;
      S_BUSY: if (exec_w) state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
    if (soft_reset_i) state_d = S_IDLE;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      state_q <= S_IDLE;
      bsy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bsy_q <= state_d == S_BUSY;
    end
  end

  // Busy counter loads on command acceptance
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) cnt_q <= '0;
    else if (wr_cmd_w) cnt_q <= BUSY_CNT_W'(BUSY_CYCLES - 1);
    else if (cnt_q != '0) cnt_q <= cnt_q - 1'b1;
  end

  // Snapshot of the parameters taken with the command
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      feat_cap_q <= TF_RESET_VAL;
      count_cap_q <= TF_RESET_VAL;
      setf_q <= 1'b0;
    end else if (wr_cmd_w) begin
      feat_cap_q <= feat_q;
      count_cap_q <= count_q;
      setf_q <= tf_wdata_i == CMD_SET_FEATURES;
    end
  end

  // ************************************
  // Option state
  // ************************************
  // Applied once at the execution point, never on abort
  always_comb begin
    opts_d = opts_q;
    if (exec_w && setf_q) begin
      case (act)
        ACT_WC_ON: opts_d.wcache = 1'b1;
        ACT_WC_OFF: opts_d.wcache = 1'b0;
        ACT_RC_ON: opts_d.rcache = 1'b1;
        ACT_RC_OFF: opts_d.rcache = 1'b0;
        ACT_APM_ON: opts_d.apm = 1'b1;
        ACT_APM_OFF: opts_d.apm = 1'b0;
        ACT_KEEP: opts_d.keep = 1'b1;
        ACT_REVERT: opts_d.keep = 1'b0;
        ACT_ECC4: opts_d.ecc4 = 1'b1;
        ACT_XFER: begin
          opts_d.xtype = xsel.xtype;
          opts_d.xmode = xsel.xmode;
        end
        default: opts_d = opts_q;
      endcase
    end
    // Soft reset restores defaults unless keeping was chosen
    if (soft_reset_i && !opts_q.keep) opts_d = OPTS_DEFAULT;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) opts_q <= OPTS_DEFAULT;
    else opts_q <= opts_d;
  end

  // Fixed capabilities, independent of any selection
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) caps_q <= 1'b1;
    else caps_q <= 1'b1;
  end

  // ************************************
  // Fault, error and interrupt
  // ************************************
  // New command clears the old outcome; abort posts it
  always_comb begin
    fault_d = fault_q;
    err_d = err_q;
    if (wr_cmd_w || soft_reset_i) begin
      fault_d = '0;
      err_d = 1'b0;
    end
    if (abort_w) begin
      fault_d = '0;
      fault_d[FAULT_ABRT_BIT] = 1'b1;
      err_d = 1'b1;
    end
  end

  // Completion beats a flag read in the same cycle
  assign irq_clr_w = rd_flags_w || wr_cmd_w || soft_reset_i;
  assign intrq_d = exec_w || (intrq_q && !irq_clr_w);

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      fault_q <= '0;
      err_q <= 1'b0;
      intrq_q <= 1'b0;
    end else begin
      fault_q <= fault_d;
      err_q <= err_d;
      intrq_q <= intrq_d;
    end
  end

  // ************************************
  // Read path
  // ************************************
  // Condition flags; seek complete always set here
  always_comb begin
    flags_w = '0;
    flags_w[FLAG_BSY_BIT] = bsy_q;
    flags_w[FLAG_DRDY_BIT] = !bsy_q;
    flags_w[FLAG_DSC_BIT] = 1'b1;
    flags_w[FLAG_ERR_BIT] = err_q;
  end

  // Registered read data; unmapped addresses read zero
  always_comb begin
    case (tf_addr_i)
      FEAT_FAULT_OFS: rdata_d = fault_q;
      BLOCK_COUNT_OFS: rdata_d = count_q;
      SECTOR_NUM_OFS: rdata_d = secnum_q;
      CYL_LOWER_OFS: rdata_d = cyl_lo_q;
      CYL_UPPER_OFS: rdata_d = cyl_hi_q;
      UNIT_HEAD_OFS: rdata_d = unit_q;
      CMD_FLAGS_OFS: rdata_d = flags_w;
      default: rdata_d = '0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) rdata_q <= '0;
    else if (tf_rd_i) rdata_q <= rdata_d;
  end

  // ************************************
  // Outputs
  // ************************************
  assign tf_rdata_o = rdata_q;
  assign intrq_o = intrq_q;
  assign opts_o = opts_q;
  assign pio4_ok_o = caps_q;
  assign mdma2_ok_o = caps_q;

  // ************************************
  // Assertions
  // ************************************
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i || soft_reset_i);

  sequence s_busy_run;
    bsy_q [*4] ##1 !bsy_q;
  endsequence

  sequence s_setf_exec(logic [7:0] code);
    exec_w && setf_q && feat_cap_q == code;
  endsequence

  a_cmd_busy: assert property (wr_cmd_w |=> bsy_q)
    else $error("command did not raise busy");

  a_busy_span: assert property ($rose(bsy_q) |-> s_busy_run)
    else $error("busy span has wrong length");

  a_done_irq: assert property (exec_w |=> intrq_q && !bsy_q)
    else $error("completion without interrupt");

  a_abort_flags: assert property (abort_w |=> err_q && fault_q[FAULT_ABRT_BIT] && $stable(opts_q))
    else $error("abort did not post flags");

  a_wcache_on: assert property (s_setf_exec(FC_WCACHE_ON) |=> opts_q.wcache && !err_q)
    else $error("write cache not enabled");

  a_rcache_off: assert property (s_setf_exec(FC_RCACHE_OFF) |=> !opts_q.rcache)
    else $error("read cache not disabled");

  a_apm_off: assert property (s_setf_exec(FC_APM_OFF) |=> !opts_q.apm)
    else $error("power management not disabled");

  a_xfer_pick: assert property (exec_w && setf_q && act == ACT_XFER
    |=> opts_q.xtype == $past(count_cap_q[7:3]) && opts_q.xmode == $past(count_cap_q[2:0]))
    else $error("transfer selection not stored");

  a_xfer_bad: assert property (s_setf_exec(FC_XFER_MODE) ##0 !xsel.ok |=> err_q ##1 !bsy_q)
    else $error("bad transfer selection not aborted");

  a_nop_keeps: assert property (exec_w && setf_q && act == ACT_NOP |=> $stable(opts_q) && !err_q)
    else $error("no-operation code changed state");

  a_ecc4_set: assert property (s_setf_exec(FC_ECC4_LONG) |=> opts_q.ecc4)
    else $error("long ECC length not selected");

  // Own reset qualifier, since the default one masks soft reset
  a_srst_revert: assert property (disable iff (!nrst_i)
    soft_reset_i && !opts_q.keep |=> opts_q == OPTS_DEFAULT)
    else $error("soft reset did not restore defaults");

  a_wr_refused: assert property (tf_wr_i && !idle_w
    |=> $stable(feat_q) && $stable(count_q) && $stable(secnum_q))
    else $error("write accepted while busy");

  a_caps_fixed: assert property (pio4_ok_o && mdma2_ok_o)
    else $error("fixed transfer capability lost");

endmodule

// >>> design/feature_decode.sv
`timescale 1ns/1ps
module feature_decode (
  // Captured parameters
  input wire logic [7:0] feat_i,
  input wire logic xfer_ok_i,
  // Decoded action
  output ata_feat_pkg::feat_act_t act_o
);
  import ata_feat_pkg::*;

  logic [NOP_CODES-1:0] nop_hit;

  // Accepted codes that change nothing
  genvar i;
  generate
    for (i = 0; i < NOP_CODES; i++) begin : g_nop
      assign nop_hit[i] = feat_i == NOP_LIST[i];
    end
  endgenerate

  // Code to action; anything unknown aborts
  function automatic feat_act_t map_code(input logic [7:0] code, input logic xok);
    case (code)
      FC_WCACHE_ON: map_code = ACT_WC_ON;
      FC_WCACHE_OFF: map_code = ACT_WC_OFF;
      FC_RCACHE_ON: map_code = ACT_RC_ON;
      FC_RCACHE_OFF: map_code = ACT_RC_OFF;
      FC_APM_ON: map_code = ACT_APM_ON;
      FC_APM_OFF: map_code = ACT_APM_OFF;
      FC_KEEP_ON_SRST: map_code = ACT_KEEP;
      FC_REVERT_ON_SRST: map_code = ACT_REVERT;
      FC_ECC4_LONG: map_code = ACT_ECC4;
      FC_XFER_MODE: map_code = xok ? ACT_XFER : ACT_ABORT;
      default: map_code = ACT_ABORT;
    endcase
  endfunction

  assign act_o = (|nop_hit) ? ACT_NOP : map_code(feat_i, xfer_ok_i);
endmodule

// >>> design/xfer_mode_decode.sv
`timescale 1ns/1ps
module xfer_mode_decode (
  // Block count value
  input wire logic [7:0] count_i,
  // Decoded selection
  output ata_feat_pkg::xfer_sel_t sel_o
);
  import ata_feat_pkg::*;

  logic [4:0] xtype_w;
  logic [2:0] xmode_w;
  logic ok_w;

  // Upper bits give the type, lower bits the binary mode
  assign xtype_w = count_i[7 -: XFER_TYPE_W];
  assign xmode_w = count_i[XFER_MODE_W-1:0];

  // Only the listed type and mode pairs pass
  assign ok_w = (xtype_w == XT_PIO_DEFAULT && xmode_w == 3'h0) ||
                (xtype_w == XT_PIO_FLOW && xmode_w <= PIO_MODE_MAX) ||
                (xtype_w == XT_MW_DMA && xmode_w <= MDMA_MODE_MAX) ||
                (xtype_w == XT_ULTRA_DMA && xmode_w <= UDMA_MODE_MAX);

  assign sel_o = '{ok: ok_w, xtype: xtype_w, xmode: xmode_w};
endmodule
